// ===== rtl/nvmcfg_pkg.sv
// Purpose: Flag decoder constants and carriers.
// Assumes: 32-bit APB words.
// Notes: Field positions are bit indices.
package nvmcfg_pkg;

    // APB register map (byte addresses)
    localparam int APB_AW = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_WAKE = 8'h08;
    localparam logic [7:0] REG_CFG0 = 8'h0C;
    localparam logic [7:0] REG_CFG1 = 8'h10;
    localparam logic [7:0] REG_FILT = 8'h14;

    // Control register
    localparam int CTRL_LOAD_EN = 0;
    localparam int CTRL_RESTART = 1;
    localparam logic LOAD_EN_RESET = 1'b1;

    // Status register
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_VALID = 2;
    localparam int STAT_IDX_ERR = 3;
    localparam int STAT_FRAME_EN = 4;

    // First wake flag byte
    localparam int W0_MASTER = 7;
    localparam int W0_MODE = 6;
    localparam int W0_LEN = 5;
    localparam int W0_POL = 4;
    localparam int W0_BUF = 3;
    localparam int W0_PKT = 1;
    localparam int W0_DA = 0;
    localparam logic [7:0] W0_USED = 8'hFB;

    // Second wake flag byte
    localparam int W1_BCAST = 1;
    localparam int W1_FRAME = 0;
    localparam logic [7:0] W1_USED = 8'h03;

    // Configuration word 0
    localparam int C0_SQU_LSB = 27;
    localparam int C0_U2I = 26;
    localparam int C0_U2 = 25;
    localparam int C0_U1I = 24;
    localparam int C0_U1 = 23;
    localparam int C0_LTM = 22;
    localparam int C0_SUSP = 20;
    localparam int C0_SNSEL_LSB = 18;
    localparam int C0_SNPOL = 17;
    localparam int C0_ADD = 16;
    localparam int C0_ASD = 15;
    localparam int C0_PLL = 7;
    localparam int C0_BOOST_LSB = 4;
    localparam int C0_SWAP = 3;
    localparam int C0_LPM = 2;
    localparam int C0_RWK = 1;
    localparam int C0_PWR = 0;
    localparam logic [31:0] C0_USED = 32'h3FDF_80FF;

    // Configuration word 1
    localparam int C1_TXD = 23;
    localparam int C1_RXD = 22;
    localparam int C1_C125 = 21;
    localparam int C1_R25 = 20;
    localparam int C1_OVL = 18;
    localparam int C1_U2X = 17;
    localparam int C1_XTAL = 16;
    localparam int C1_BO_LSB = 12;
    localparam int C1_BI_LSB = 8;
    localparam logic [31:0] C1_USED = 32'h00F7_FF00;

    // Wake frame filter image: configuration word then byte mask
    localparam int FILT_WORDS = 5;
    localparam int FILT_CFG_BYTES = 4;

    typedef enum logic [2:0] {
        SEL_WAKE0 = 3'h0,
        SEL_WAKE1 = 3'h1,
        SEL_CFG0 = 3'h2,
        SEL_CFG1 = 3'h3,
        SEL_FILT = 3'h4
    } nvmcfg_sel_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_LOAD = 2'h1,
        ST_APPLY = 2'h3,
        ST_DONE = 2'h2
    } nvmcfg_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [APB_AW-1:0] paddr;
        logic [31:0] pwdata;
    } nvmcfg_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } nvmcfg_apb_rsp_t;

    typedef struct packed {
        logic valid;
        nvmcfg_sel_t sel;
        logic [7:0] idx;
        logic [31:0] data;
    } nvmcfg_rec_t;

    typedef struct packed {
        logic valid;
        logic [7:0] idx;
        logic [31:0] data;
    } nvmcfg_frame_wr_t;

    typedef struct packed {
        logic wake_master_en;
        logic signal_pulse;
        logic pulse_long;
        logic polarity_high;
        logic push_pull;
        logic packet_en;
        logic perfect_da_en;
        logic bcast_en;
        logic wake_frame_en;
    } nvmcfg_flag_attributes_reg_t;

    typedef struct packed {
        logic [3:0] bulk_out_burst;
        logic [3:0] bulk_in_burst;
        logic lfps_overlap_check_en;
        logic deep_lp_exit_lfps;
        logic suspend_allow;
        logic lane_swap;
        logic link_power_capable;
        logic remote_wake;
        logic power_method;
    } nvmcfg_usb0_t;

    typedef struct packed {
        logic device_deep_lp_initiate_en;
        logic device_deep_lp_en;
        logic device_shallow_lp_initiate_en;
        logic device_shallow_lp_en;
        logic latency_msg_en;
    } nvmcfg_usb1_t;

    typedef struct packed {
        logic [1:0] suspend_pin_select;
        logic suspend_pin_polarity;
        logic gen_125mhz_clock_en;
        logic ref_25mhz_out_en;
    } nvmcfg_hw_t;

    typedef struct packed {
        logic auto_duplex;
        logic auto_speed;
        logic txc_delay_en;
        logic rxc_delay_en;
    } nvmcfg_mac_t;

    typedef struct packed {
        logic [2:0] hs_squelch_tune;
        logic [2:0] hs_output_current;
        logic pll_link_power_mode;
        logic crystal_suspend_disable;
    } nvmcfg_phy_t;

endpackage : nvmcfg_pkg

// ===== rtl/nvmcfg_filt_mem.sv
// Purpose: Byte-writable filter image store.
// Assumes: One clock.
// Notes: Registered read data.
module nvmcfg_filt_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 5
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Write port
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH/8-1:0] wr_be,
    input wire logic [WIDTH-1:0] wr_data,
    // Read port
    input wire logic rd_en,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    if (WIDTH % 8 != 0 || DEPTH < 2) begin : g_chk
        $error("bad width or depth");
    end

    // One process, so the array has a single writer
    always_ff @(posedge clk_sys) begin
        for (int b = 0; b < WIDTH / 8; b++) begin
            if (wr_en && wr_be[b]) begin
                mem_q[wr_addr][b*8 +: 8] <= wr_data[b*8 +: 8];
            end
        end
    end

    // Out-of-range reads give zero
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= (32'(rd_addr) < DEPTH) ? mem_q[rd_addr] : '0;
        end
    end
endmodule : nvmcfg_filt_mem

// ===== rtl/nvmcfg_decoder.sv
// Purpose: Turn reader records
//          into register defaults.
// Assumes: Reader inputs synchronous.
// Notes: Defaults count once defaults_valid is high.

// Functional notes
// (R1) First byte bit 1 enables packet wake
// (R2) First byte bit 0 enables exact-address wake
// (R3) Master bit clear masks packet and address enables
// (R4) Second byte 7:2 reserved, bit 1 broadcast wake
// (R5) Second byte bit 0 loads frame filter 0
// (R6) Both bytes default the flag attributes fields
// (R7) Image author keeps descriptor consistent with word 0
// (R8) Word 0 bits 29:27 default squelch tune
// (R9) Word 0 bits 26:23 default low-power enables
// (R10) Word 0 bit 22 latency, bit 20 suspend
// (R11) Word 0 19:18 suspend pin select, 17 polarity
// (R12) Word 0 bit 16 duplex, 15 speed detection
// (R13) Word 0 bit 7 PLL mode, 6:4 boost
// (R14) Word 0 bits 3:0 swap, LPM, wake, power
// (R15) Word 1 bits 23:22 interface clock delays
// (R16) Word 1 bits 21:20 clock output enables
// (R17) Word 1 18:17 LFPS bits, 16 crystal suspend
// (R18) Word 1 15:12 and 11:8 burst sizes
// (R19) First byte bit 7 is wake master enable
// (R20) Filter image: four config, sixteen mask bytes
// (R21) Reserved bits never reach any default
module nvmcfg_decoder #(
    parameter int FILT_NWORDS = nvmcfg_pkg::FILT_WORDS
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // APB slave
    input wire nvmcfg_pkg::nvmcfg_apb_req_t apb_req,
    output nvmcfg_pkg::nvmcfg_apb_rsp_t apb_rsp,
    // Nonvolatile reader records
    input wire nvmcfg_pkg::nvmcfg_rec_t nvm_rec,
    input wire logic nvm_done,
    // Register defaults
    output nvmcfg_pkg::nvmcfg_flag_attributes_reg_t flag_attributes_dflt,
    output nvmcfg_pkg::nvmcfg_usb0_t usb_config_reg_zero_dflt,
    output nvmcfg_pkg::nvmcfg_usb1_t usb_config_reg_one_dflt,
    output nvmcfg_pkg::nvmcfg_hw_t hardware_config_dflt,
    output nvmcfg_pkg::nvmcfg_mac_t mac_dflt,
    output nvmcfg_pkg::nvmcfg_phy_t phy_pm_dflt,
    output logic defaults_valid,
    // Wake frame filter 0 load
    output nvmcfg_pkg::nvmcfg_frame_wr_t wake_frame_filter_wr
);
    import nvmcfg_pkg::*;

    localparam int AW = $clog2(FILT_NWORDS);
    localparam int FILT_BYTES = 4 * FILT_NWORDS;
    localparam logic [8:0] FILT_END = 9'(32'(REG_FILT) + FILT_BYTES);
    localparam logic [AW-1:0] LAST_PTR = AW'(FILT_NWORDS - 1);

    // Index field is 8 bits
    if (FILT_NWORDS < FILT_WORDS || FILT_BYTES > 256 || FILT_END > 9'h100) begin : g_chk
        $error("FILT_NWORDS out of range");
    end

    // State
    nvmcfg_state_t state_q;
    nvmcfg_state_t state_d;
    logic load_en_q;
    logic [7:0] wake0_q;
    logic [7:0] wake1_q;
    logic [31:0] cfg0_q;
    logic [31:0] cfg1_q;
    logic idx_err_q;
    logic [AW-1:0] ptr_q;
    logic issued_q;
    logic [AW-1:0] issued_idx_q;
    logic rd_apb_q;
    logic [31:0] rdata_q;
    logic valid_q;
    logic [31:0] mem_rd;

    // APB decode
    wire logic setup = apb_req.psel & ~apb_req.penable;
    wire logic access = apb_req.psel & apb_req.penable;
    wire logic hit_ctrl = apb_req.paddr == REG_CTRL;
    wire logic hit_stat = apb_req.paddr == REG_STAT;
    wire logic hit_wake = apb_req.paddr == REG_WAKE;
    wire logic hit_cfg0 = apb_req.paddr == REG_CFG0;
    wire logic hit_cfg1 = apb_req.paddr == REG_CFG1;
    wire logic hit_filt = ({1'b0, apb_req.paddr} >= {1'b0, REG_FILT})
                        && ({1'b0, apb_req.paddr} < FILT_END)
                        && (apb_req.paddr[1:0] == 2'h0);
    wire logic mapped = hit_ctrl | hit_stat | hit_wake | hit_cfg0 | hit_cfg1 | hit_filt;
    wire logic [7:0] filt_off = apb_req.paddr - REG_FILT;
    wire logic [AW-1:0] filt_word = AW'(filt_off[7:2]);
    wire logic apply_busy = state_q == ST_APPLY;
    // Filter reads wait out an apply
    wire logic pready = ~hit_filt | rd_apb_q;
    wire logic apb_done = access & pready;
    wire logic apb_rd_issue = apb_req.psel & hit_filt & ~apply_busy & ~apb_done;
    wire logic wr_fire = apb_done & apb_req.pwrite & mapped;
    wire logic restart = wr_fire & hit_ctrl & apb_req.pwdata[CTRL_RESTART];

    // Reader record acceptance
    wire logic rec_open = (state_q == ST_IDLE) | (state_q == ST_LOAD);
    wire logic rec_take = nvm_rec.valid & load_en_q & rec_open & ~restart;
    wire logic take_w0 = rec_take & (nvm_rec.sel == SEL_WAKE0);
    wire logic take_w1 = rec_take & (nvm_rec.sel == SEL_WAKE1);
    wire logic take_c0 = rec_take & (nvm_rec.sel == SEL_CFG0);
    wire logic take_c1 = rec_take & (nvm_rec.sel == SEL_CFG1);
    wire logic take_f = rec_take & (nvm_rec.sel == SEL_FILT);
    wire logic filt_idx_ok = 32'(nvm_rec.idx) < FILT_BYTES;
    wire logic filt_wr = take_f & filt_idx_ok;
    wire logic filt_bad = take_f & ~filt_idx_ok;
    wire logic done_take = nvm_done & load_en_q & rec_open;

    // Wake flag decode
    wire logic master_en = wake0_q[W0_MASTER]; // see (R19)
    wire logic frame_en = wake1_q[W1_FRAME]; // see (R5)

    // Filter store: byte n lands in word n/4, lane n%4
    wire logic [AW-1:0] mem_wr_addr = AW'(nvm_rec.idx[7:2]); // see (R20)
    wire logic [3:0] mem_be = 4'(4'h1 << nvm_rec.idx[1:0]);
    wire logic [31:0] mem_wdata = {4{nvm_rec.data[7:0]}};
    wire logic mem_rd_en = apply_busy | apb_rd_issue;
    wire logic [AW-1:0] mem_rd_addr = apply_busy ? ptr_q : filt_word;

    nvmcfg_filt_mem #(
        .WIDTH(32),
        .DEPTH(FILT_NWORDS)
    ) u_filt_mem (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .wr_en(filt_wr),
        .wr_addr(mem_wr_addr),
        .wr_be(mem_be),
        .wr_data(mem_wdata),
        .rd_en(mem_rd_en),
        .rd_addr(mem_rd_addr),
        .rd_data(mem_rd)
    );

    // Sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (rec_take) begin
                    state_d = ST_LOAD;
                end else if (done_take) begin
                    state_d = ST_DONE;
                end
            end
            ST_LOAD: begin
                if (done_take) begin
                    state_d = frame_en ? ST_APPLY : ST_DONE; // see (R5)
                end
            end
            ST_APPLY: begin
                if (ptr_q == LAST_PTR) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                state_d = ST_DONE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (restart) begin
            state_d = ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            ptr_q <= '0;
            issued_q <= 1'b0;
            issued_idx_q <= '0;
        end else begin
            state_q <= state_d;
            ptr_q <= (apply_busy && state_d == ST_APPLY) ? ptr_q + AW'(1) : '0;
            issued_q <= apply_busy;
            issued_idx_q <= ptr_q;
        end
    end

    // Captured flags, reserved positions dropped on entry
    always_ff @(posedge clk_sys) begin
        if (!nrst || restart) begin
            wake0_q <= 8'h00;
            wake1_q <= 8'h00;
            cfg0_q <= 32'h0000_0000;
            cfg1_q <= 32'h0000_0000;
        end else begin
            if (take_w0) begin
                wake0_q <= nvm_rec.data[7:0] & W0_USED; // see (R21)
            end
            if (take_w1) begin
                wake1_q <= nvm_rec.data[7:0] & W1_USED; // see (R4) see (R21)
            end
            if (take_c0) begin
                cfg0_q <= nvm_rec.data & C0_USED; // see (R21)
            end
            if (take_c1) begin
                cfg1_q <= nvm_rec.data & C1_USED; // see (R21)
            end
        end
    end

    // Sticky; restart wins, as no record is taken in a restart cycle
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            idx_err_q <= 1'b0;
        end else if (filt_bad) begin
            idx_err_q <= 1'b1;
        end else if (restart) begin
            idx_err_q <= 1'b0;
        end
    end

    // Software control
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            load_en_q <= LOAD_EN_RESET;
        end else if (wr_fire && hit_ctrl) begin
            load_en_q <= apb_req.pwdata[CTRL_LOAD_EN];
        end
    end

    // Default fields
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            flag_attributes_dflt <= '0;
            usb_config_reg_zero_dflt <= '0;
            usb_config_reg_one_dflt <= '0;
            hardware_config_dflt <= '0;
            mac_dflt <= '0;
            phy_pm_dflt <= '0;
            valid_q <= 1'b0;
        end else begin
            // Pin style needs the master bit
            flag_attributes_dflt.wake_master_en <= master_en; // see (R6)
            flag_attributes_dflt.signal_pulse <= master_en & wake0_q[W0_MODE];
            flag_attributes_dflt.pulse_long <= master_en & wake0_q[W0_LEN];
            flag_attributes_dflt.polarity_high <= master_en & wake0_q[W0_POL];
            flag_attributes_dflt.push_pull <= master_en & wake0_q[W0_BUF];
            flag_attributes_dflt.packet_en <= master_en & wake0_q[W0_PKT]; // see (R1) see (R3)
            flag_attributes_dflt.perfect_da_en <= master_en & wake0_q[W0_DA]; // see (R2) see (R3)
            flag_attributes_dflt.bcast_en <= wake1_q[W1_BCAST]; // see (R4)
            flag_attributes_dflt.wake_frame_en <= frame_en; // see (R5) see (R6)

            phy_pm_dflt.hs_squelch_tune <= cfg0_q[C0_SQU_LSB +: 3]; // see (R8)
            phy_pm_dflt.hs_output_current <= cfg0_q[C0_BOOST_LSB +: 3]; // see (R13)
            phy_pm_dflt.pll_link_power_mode <= cfg0_q[C0_PLL]; // see (R13)
            phy_pm_dflt.crystal_suspend_disable <= cfg1_q[C1_XTAL]; // see (R17)

            usb_config_reg_one_dflt.device_deep_lp_initiate_en <= cfg0_q[C0_U2I]; // see (R9)
            usb_config_reg_one_dflt.device_deep_lp_en <= cfg0_q[C0_U2]; // see (R9)
            usb_config_reg_one_dflt.device_shallow_lp_initiate_en <= cfg0_q[C0_U1I]; // see (R9)
            usb_config_reg_one_dflt.device_shallow_lp_en <= cfg0_q[C0_U1]; // see (R9)
            usb_config_reg_one_dflt.latency_msg_en <= cfg0_q[C0_LTM]; // see (R10)

            usb_config_reg_zero_dflt.suspend_allow <= cfg0_q[C0_SUSP]; // see (R10)
            usb_config_reg_zero_dflt.lane_swap <= cfg0_q[C0_SWAP]; // see (R14)
            usb_config_reg_zero_dflt.link_power_capable <= cfg0_q[C0_LPM]; // see (R14)
            usb_config_reg_zero_dflt.remote_wake <= cfg0_q[C0_RWK]; // see (R14)
            usb_config_reg_zero_dflt.power_method <= cfg0_q[C0_PWR]; // see (R14)
            usb_config_reg_zero_dflt.lfps_overlap_check_en <= cfg1_q[C1_OVL]; // see (R17)
            usb_config_reg_zero_dflt.deep_lp_exit_lfps <= cfg1_q[C1_U2X]; // see (R17)
            usb_config_reg_zero_dflt.bulk_out_burst <= cfg1_q[C1_BO_LSB +: 4]; // see (R18)
            usb_config_reg_zero_dflt.bulk_in_burst <= cfg1_q[C1_BI_LSB +: 4]; // see (R18)

            hardware_config_dflt.suspend_pin_select <= cfg0_q[C0_SNSEL_LSB +: 2]; // see (R11)
            hardware_config_dflt.suspend_pin_polarity <= cfg0_q[C0_SNPOL]; // see (R11)
            hardware_config_dflt.gen_125mhz_clock_en <= cfg1_q[C1_C125]; // see (R16)
            hardware_config_dflt.ref_25mhz_out_en <= cfg1_q[C1_R25]; // see (R16)

            mac_dflt.auto_duplex <= cfg0_q[C0_ADD]; // see (R12)
            mac_dflt.auto_speed <= cfg0_q[C0_ASD]; // see (R12)
            mac_dflt.txc_delay_en <= cfg1_q[C1_TXD]; // see (R15)
            mac_dflt.rxc_delay_en <= cfg1_q[C1_RXD]; // see (R15)

            valid_q <= state_d == ST_DONE;
        end
    end

    assign defaults_valid = valid_q;

    // One filter word per cycle
    assign wake_frame_filter_wr.valid = issued_q; // see (R5) see (R20)
    assign wake_frame_filter_wr.idx = 8'(issued_idx_q);
    assign wake_frame_filter_wr.data = mem_rd;

    // Sampled in setup, one edge old
    wire logic [31:0] stat_word = {27'h0, frame_en, idx_err_q, valid_q, state_q};
    wire logic [31:0] ctrl_word = {31'h0, load_en_q};
    wire logic [31:0] wake_word = {16'h0, wake1_q, wake0_q};
    wire logic [31:0] rd_mux = hit_ctrl ? ctrl_word
                             : hit_stat ? stat_word
                             : hit_wake ? wake_word
                             : hit_cfg0 ? cfg0_q
                             : hit_cfg1 ? cfg1_q
                             : 32'h0000_0000;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rdata_q <= 32'h0000_0000;
            rd_apb_q <= 1'b0;
        end else begin
            if (setup) begin
                rdata_q <= rd_mux;
            end
            rd_apb_q <= apb_rd_issue;
        end
    end

    assign apb_rsp.pready = pready;
    assign apb_rsp.pslverr = access & ~mapped;
    assign apb_rsp.prdata = hit_filt ? mem_rd : rdata_q;
endmodule : nvmcfg_decoder

// ===== verif/nvmcfg_monitor.sv
// Purpose: Port checks of the flag decoder.
// Assumes: Load enable stays set.
// Notes: open_q mirrors the record window.
module nvmcfg_monitor #(
    parameter int FILT_NWORDS = 5
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Bus and reader
    input wire nvmcfg_pkg::nvmcfg_apb_req_t apb_req,
    input wire nvmcfg_pkg::nvmcfg_apb_rsp_t apb_rsp,
    input wire nvmcfg_pkg::nvmcfg_rec_t nvm_rec,
    input wire logic nvm_done,
    // Defaults
    input wire nvmcfg_pkg::nvmcfg_flag_attributes_reg_t flag_attributes_dflt,
    input wire nvmcfg_pkg::nvmcfg_usb0_t usb_config_reg_zero_dflt,
    input wire nvmcfg_pkg::nvmcfg_usb1_t usb_config_reg_one_dflt,
    input wire nvmcfg_pkg::nvmcfg_hw_t hardware_config_dflt,
    input wire nvmcfg_pkg::nvmcfg_mac_t mac_dflt,
    input wire nvmcfg_pkg::nvmcfg_phy_t phy_pm_dflt,
    input wire logic defaults_valid,
    input wire nvmcfg_pkg::nvmcfg_frame_wr_t wake_frame_filter_wr
);
    import nvmcfg_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    logic open_q;
    logic [31:0] d1_q;
    logic [31:0] d2_q;
    nvmcfg_flag_attributes_reg_t fa;
    nvmcfg_frame_wr_t fw;
    assign fa = flag_attributes_dflt;
    assign fw = wake_frame_filter_wr;
    wire logic acc = apb_req.psel && apb_req.penable;
    wire logic rst_wr = acc && apb_rsp.pready && apb_req.pwrite && apb_req.paddr == REG_CTRL
        && apb_req.pwdata[CTRL_RESTART];
    wire logic tk = nvm_rec.valid && open_q && !rst_wr;
    // Data delayed to match outputs
    always_ff @(posedge clk_sys) begin
        open_q <= !nrst || rst_wr || (open_q && !nvm_done);
        d1_q <= nvm_rec.data;
        d2_q <= d1_q;
    end
    gate_a: assert property (
        (fa.packet_en || fa.perfect_da_en) |-> fa.wake_master_en) else $error("event without master");
    pin_style_a: assert property (
        |{fa.signal_pulse, fa.pulse_long, fa.polarity_high, fa.push_pull} |-> fa.wake_master_en)
        else $error("pin style");
    wake_byte_a: assert property (
        tk && nvm_rec.sel == SEL_WAKE0 |-> ##2 {fa.wake_master_en, fa.packet_en, fa.perfect_da_en}
        == {d2_q[7], d2_q[7] & d2_q[1], d2_q[7] & d2_q[0]}) else $error("wake byte 0 wrong");
    wake_second_a: assert property (
        tk && nvm_rec.sel == SEL_WAKE1 |-> ##2 {fa.bcast_en, fa.wake_frame_en} == d2_q[1:0])
        else $error("wake byte 1 wrong");
    word_zero_a: assert property (
        tk && nvm_rec.sel == SEL_CFG0 |-> ##2 usb_config_reg_one_dflt == d2_q[26:22]
        && phy_pm_dflt.hs_squelch_tune == d2_q[29:27]) else $error("word 0 wrong");
    word_one_a: assert property (
        tk && nvm_rec.sel == SEL_CFG1 |-> ##2 {usb_config_reg_zero_dflt.bulk_out_burst,
        usb_config_reg_zero_dflt.bulk_in_burst, mac_dflt.txc_delay_en, mac_dflt.rxc_delay_en}
        == {d2_q[15:8], d2_q[23:22]}) else $error("word 1 wrong");
    done_plain_a: assert property (
        nvm_done && open_q && !fa.wake_frame_en && !nvm_rec.valid && !$past(nvm_rec.valid)
        |-> ##[1:2] defaults_valid) else $error("no valid");
    filt_run_a: assert property (
        fw.valid && fw.idx != 8'(FILT_NWORDS - 1) |-> ##1 fw.valid && fw.idx == $past(fw.idx) + 8'h01)
        else $error("filter gap");
    filt_end_a: assert property (
        fw.valid && fw.idx == 8'(FILT_NWORDS - 1) |-> defaults_valid ##1 !fw.valid)
        else $error("filter end");
    unmapped_a: assert property (
        acc && apb_req.paddr > 8'h24 |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000)
        else $error("unmapped");
endmodule : nvmcfg_monitor

bind nvmcfg_decoder nvmcfg_monitor #(.FILT_NWORDS(FILT_NWORDS)) u_mon (.*);

// ===== verif/nvmcfg_rdr_model.sv
// Purpose: Reader model.
// Assumes: One-cycle record strobes.
// Notes: Idle lines carry inverted data.
module nvmcfg_rdr_model (
    // Clock
    input wire logic clk_sys,
    // Records
    output nvmcfg_pkg::nvmcfg_rec_t nvm_rec,
    output logic nvm_done
);
    import nvmcfg_pkg::*;
    initial begin
        nvm_rec = '0;
        nvm_done = 1'b0;
    end
    // Image kept consistent
    task automatic send(input nvmcfg_sel_t sel, input logic [7:0] idx, input logic [31:0] d);
        @(posedge clk_sys);
        nvm_rec <= '{1'b1, sel, idx, d};
        @(posedge clk_sys);
        nvm_rec <= '{1'b0, sel, ~idx, ~d};
    endtask : send
    // Done strobe held for one cycle
    task automatic finish();
        @(posedge clk_sys);
        nvm_done <= 1'b1;
        @(posedge clk_sys);
        nvm_done <= 1'b0;
    endtask : finish
endmodule : nvmcfg_rdr_model

// ===== verif/nvm_config_flag_decoder_tb_top.sv
// Purpose: Flag decoder bench.
// Assumes: Reader model feeds records.
// Notes: Expectations from bit positions.
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module nvm_config_flag_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import nvmcfg_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    nvmcfg_apb_req_t apb_req = '0;
    nvmcfg_apb_rsp_t apb_rsp;
    nvmcfg_rec_t nvm_rec;
    logic nvm_done;
    nvmcfg_flag_attributes_reg_t fa;
    nvmcfg_usb0_t u0;
    nvmcfg_usb1_t u1;
    nvmcfg_hw_t hw;
    nvmcfg_mac_t mac;
    nvmcfg_phy_t phy;
    nvmcfg_frame_wr_t fw;
    logic dv;
    logic er;
    logic [31:0] rd, c0, c1;
    logic [31:0] pat [4] = '{32'hFFFF_FFFF, 32'h2AAA_AAAA, 32'h1555_5555, 32'h0000_0000};
    int n_errors = 0;
    int checked = 0;
    int k, j;
    always #50 clk_sys = ~clk_sys;
    nvmcfg_decoder u_dut (.clk_sys(clk_sys), .nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .nvm_rec(nvm_rec), .nvm_done(nvm_done), .flag_attributes_dflt(fa),
        .usb_config_reg_zero_dflt(u0), .usb_config_reg_one_dflt(u1), .hardware_config_dflt(hw),
        .mac_dflt(mac), .phy_pm_dflt(phy), .defaults_valid(dv), .wake_frame_filter_wr(fw));
    nvmcfg_rdr_model u_rdr (.clk_sys(clk_sys), .nvm_rec(nvm_rec), .nvm_done(nvm_done));
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out
    task automatic fail(input string m);
        $display("[ERR] %s", m);
        n_errors++;
        close_out();
    endtask : fail
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : wt
    // Answer read mid-cycle, where it stands until the edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        logic p;
        int i;
        @(posedge clk_sys);
        apb_req <= '{1'b1, 1'b0, w, a, wd};
        @(posedge clk_sys);
        apb_req.penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(negedge clk_sys);
            p = apb_rsp.pready;
            rd = apb_rsp.prdata;
            er = apb_rsp.pslverr;
            @(posedge clk_sys);
            if (p === 1'b1) break;
        end
        if (i == 20) fail("pready timeout");
        apb_req <= '0;
    endtask : apb
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("prdata", e, rd)
    endtask : rdchk
    initial begin
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        rdchk(REG_STAT, 32'h0000_0000);
        rdchk(REG_CTRL, 32'h0000_0001);
        apb(1'b0, 8'h40, 32'h0);
        `CHK("pslverr", 1'b1, er)
        apb(1'b1, REG_STAT, 32'hFFFF_FFFF);
        rdchk(REG_STAT, 32'h0000_0000);
        u_rdr.send(SEL_WAKE0, 8'h00, 32'h0000_007B);
        wt(2);
        `CHK("attr", 9'h000, fa)
        u_rdr.send(SEL_WAKE0, 8'h00, 32'h0000_00FF);
        u_rdr.send(SEL_WAKE1, 8'h00, 32'h0000_00FE);
        wt(2);
        `CHK("attr", 9'h1FE, fa)
        u_rdr.send(SEL_WAKE0, 8'h00, 32'h0000_0082);
        wt(2);
        `CHK("attr", 9'h10A, fa)
        u_rdr.send(SEL_WAKE0, 8'h00, 32'h0000_0081);
        wt(2);
        `CHK("attr", 9'h106, fa)
        foreach (pat[i]) begin
            c0 = pat[i];
            c1 = ~pat[i];
            u_rdr.send(SEL_CFG0, 8'h00, c0);
            u_rdr.send(SEL_CFG1, 8'h00, c1);
            wt(2);
            `CHK("usb0", {c1[15:8], c1[18:17], c0[20], c0[3:0]}, u0)
            `CHK("usb1", c0[26:22], u1)
            `CHK("hw", {c0[19:17], c1[21:20]}, hw)
            `CHK("mac", {c0[16:15], c1[23:22]}, mac)
            `CHK("phy", {c0[29:27], c0[6:4], c0[7], c1[16]}, phy)
            rdchk(REG_CFG1, c1 & C1_USED);
        end
        u_rdr.send(SEL_WAKE1, 8'h00, 32'h0000_0001);
        for (k = 0; k < 20; k++) u_rdr.send(SEL_FILT, k[7:0], 32'h30 + k);
        u_rdr.finish();
        for (k = 0; k < 9 && fw.valid !== 1'b1; k++) wt(1);
        if (k == 9) fail("filter timeout");
        for (j = 0; j < 5; j++) begin
            `CHK("filt", {1'b1, j[7:0], 32'h3332_3130 + 32'h0404_0404 * j}, fw)
            wt(1);
        end
        `CHK("valid", 1'b1, dv)
        rdchk(REG_STAT, 32'h0000_0016);
        rdchk(REG_FILT + 8'h04, 32'h3736_3534);
        u_rdr.send(SEL_CFG1, 8'h00, 32'h0000_0000);
        wt(2);
        `CHK("mac", 4'h3, mac)
        apb(1'b1, REG_CTRL, 32'h0000_0003);
        rdchk(REG_STAT, 32'h0000_0000);
        `CHK("usb0", 15'h0000, u0)
        u_rdr.send(SEL_FILT, 8'd20, 32'h0000_0000);
        apb(1'b0, REG_STAT, 32'h0);
        `CHK("badidx", 1'b1, rd[STAT_IDX_ERR])
        apb(1'b1, REG_CTRL, 32'h0000_0003);
        u_rdr.finish();
        wt(2);
        `CHK("valid", 1'b1, dv)
        `CHK("attr", 9'h000, fa)
        close_out();
    end
endmodule : nvm_config_flag_decoder_tb_top
